// ### verilog/sbuf_params.svh
`ifndef SBUF_PARAMS_SVH
`define SBUF_PARAMS_SVH

// Register byte offsets
`define SBUF_OFS_BOARD_CTRL 8'h00
`define SBUF_OFS_LEVEL_CTRL 8'h38
`define SBUF_OFS_COUNT 8'h40
`define SBUF_OFS_SAMPLE_READ 8'h48

// Board control fields
`define SBUF_BCR_CFG_LSB 0
`define SBUF_BCR_SPAN_LSB 2
`define SBUF_BCR_FMT_BIT 4
`define SBUF_BCR_SYNC_BIT 6
`define SBUF_BCR_SETTLED_BIT 13
`define SBUF_BCR_FILL_BIT 14

// Level control fields
`define SBUF_LVL_INTAKE_OFF_BIT 18
`define SBUF_LVL_FLUSH_BIT 19

// Reset values
`define SBUF_RST_CFG 2'h0
`define SBUF_RST_SPAN 2'h3
`define SBUF_RST_FMT 1'h1
`define SBUF_RST_THRESH 18'h3FFFE

// Settling length in conversion intervals, 130
`define SBUF_SETTLE_INTERVALS 8'h82

`endif

// ### verilog/sbuf_pkg.sv
package sbuf_pkg;

	typedef enum logic [1:0] {
		CFG_DIFFERENTIAL,
		CFG_SINGLE_ENDED,
		CFG_GROUND_TEST,
		CFG_REFERENCE_TEST
	} input_config_e;

	typedef enum logic [1:0] {
		SPAN_1V25,
		SPAN_2V5,
		SPAN_5V,
		SPAN_10V
	} input_span_e;

	typedef struct packed {
		input_config_e input_config_select;
		input_span_e span;
		logic fmt_offset;
		logic [17:0] thresh;
		logic intake_off;
		logic flush;
		logic settled;
		logic [7:0] settle_cnt;
		logic fill_flag;
		logic settled_evt;
		logic fill_evt;
		logic sync_pulse;
		logic [18:0] level;
		logic [31:0] rdata;
		logic rvalid;
	} sbuf_state_s;

endpackage

// ### verilog/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 256,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_flush,
	input wire logic i_push,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic i_pop,
	output logic [WIDTH-1:0] o_rdata,
	output logic o_full,
	output logic o_empty,
	output logic [AW:0] o_count
);

	localparam logic [AW:0] DEPTH_COUNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} fifo_s;

	fifo_s st_r;
	fifo_s st_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic do_push;
	logic do_pop;

	assign o_full = (st_r.count == DEPTH_COUNT);
	assign o_empty = (st_r.count == '0);
	assign o_count = st_r.count;
	// Empty read shows stale contents, which is acceptable for this port
	assign o_rdata = mem[st_r.rd_ptr];
	assign do_push = i_push && !o_full && !i_flush;
	assign do_pop = i_pop && !o_empty && !i_flush;

	always_comb begin
		st_nxt = st_r;
		if (i_flush) begin
			st_nxt = '0;
		end else begin
			if (do_push) begin
				st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
			end
			if (do_pop) begin
				st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
			end
			st_nxt.count = st_r.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (do_push) begin
			mem[st_r.wr_ptr] <= i_wdata;
		end
	end

endmodule // sample_fifo

// ### verilog/sample_buffer_and_input_config.sv
`timescale 1ns/1ps
`include "sbuf_params.svh"
module sample_buffer_and_input_config #(
	parameter int XFER_DEPTH = 256,
	parameter int STORE_DEPTH = 262144
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] i_wdata,
	input wire logic i_sample_valid,
	input wire logic [15:0] i_sample_data,
	input wire logic [3:0] i_sample_chan,
	input wire logic i_conv_tick,
	input wire logic i_rate_change,
	input wire logic i_autocal_start,
	input wire logic i_fill_rising_sel,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	output logic [1:0] o_input_config_select,
	output logic [1:0] o_input_span,
	output logic o_conv_sync,
	output logic o_settled_event,
	output logic o_fill_event
);

	localparam int XAW = $clog2(XFER_DEPTH);
	localparam int SAW = $clog2(STORE_DEPTH);

	////////////////////////////////////////////////////////////////////////////
	// State

	sbuf_pkg::sbuf_state_s st_r;
	sbuf_pkg::sbuf_state_s st_nxt;

	logic [19:0] xf_wdata;
	logic [19:0] xf_rdata;
	logic xf_push;
	logic xf_pop;
	logic xf_full;
	logic xf_empty;
	logic [XAW:0] xf_count;
	logic [19:0] st_head;
	logic st_full;
	logic st_empty;
	logic [SAW:0] st_count;
	logic [18:0] total;
	logic bcr_wr;
	logic lvl_wr;
	logic data_rd;
	logic [31:0] bcr_view;
	logic param_change;

	////////////////////////////////////////////////////////////////////////////
	// Sample intake and the two-stage store

	// Converter words arrive as two's complement; MSB flip gives offset binary
	assign xf_wdata = {i_sample_chan,
		i_sample_data[15] ^ st_r.fmt_offset, i_sample_data[14:0]};
	// Blocked intake drops words at the source so stored entries stay
	assign xf_push = i_sample_valid && !st_r.intake_off && !st_r.flush && !xf_full;
	// Move words on whenever the main store has room
	assign xf_pop = !xf_empty && !st_full;

	sample_fifo #(
		.WIDTH(20),
		.DEPTH(XFER_DEPTH),
		.AW(XAW)
	) u_xfer (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_flush(st_r.flush),
		.i_push(xf_push),
		.i_wdata(xf_wdata),
		.i_pop(xf_pop),
		.o_rdata(xf_rdata),
		.o_full(xf_full),
		.o_empty(xf_empty),
		.o_count(xf_count)
	);

	sample_fifo #(
		.WIDTH(20),
		.DEPTH(STORE_DEPTH),
		.AW(SAW)
	) u_store (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_flush(st_r.flush),
		.i_push(xf_pop),
		.i_wdata(xf_rdata),
		.i_pop(data_rd),
		.o_rdata(st_head),
		.o_full(st_full),
		.o_empty(st_empty),
		.o_count(st_count)
	);

	// Both stages count toward the level
	assign total = 19'(st_count) + 19'(xf_count);

	////////////////////////////////////////////////////////////////////////////
	// Register decode

	assign bcr_wr = i_wr && (i_addr == `SBUF_OFS_BOARD_CTRL);
	assign lvl_wr = i_wr && (i_addr == `SBUF_OFS_LEVEL_CTRL);
	assign data_rd = i_rd && (i_addr == `SBUF_OFS_SAMPLE_READ);

	always_comb begin
		bcr_view = '0;
		bcr_view[`SBUF_BCR_CFG_LSB +: 2] = st_r.input_config_select;
		bcr_view[`SBUF_BCR_SPAN_LSB +: 2] = st_r.span;
		bcr_view[`SBUF_BCR_FMT_BIT] = st_r.fmt_offset;
		bcr_view[`SBUF_BCR_SETTLED_BIT] = st_r.settled;
		bcr_view[`SBUF_BCR_FILL_BIT] = st_r.fill_flag;
	end

	// Range, config or rate change restarts settling; format does not
	assign param_change = i_rate_change || (bcr_wr &&
		((i_wdata[`SBUF_BCR_CFG_LSB +: 2] != st_r.input_config_select) ||
		(i_wdata[`SBUF_BCR_SPAN_LSB +: 2] != st_r.span)));

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		st_nxt.settled_evt = 1'b0;
		st_nxt.fill_evt = 1'b0;
		st_nxt.sync_pulse = 1'b0;
		st_nxt.rvalid = 1'b0;

		if (bcr_wr) begin
			// Config reroutes the front end; a changed value also restarts settling
			st_nxt.input_config_select =
				sbuf_pkg::input_config_e'(i_wdata[`SBUF_BCR_CFG_LSB +: 2]);
			st_nxt.span = sbuf_pkg::input_span_e'(i_wdata[`SBUF_BCR_SPAN_LSB +: 2]);
			st_nxt.fmt_offset = i_wdata[`SBUF_BCR_FMT_BIT];
			st_nxt.sync_pulse = i_wdata[`SBUF_BCR_SYNC_BIT];
		end
		if (lvl_wr) begin
			st_nxt.thresh = i_wdata[17:0];
			st_nxt.intake_off = i_wdata[`SBUF_LVL_INTAKE_OFF_BIT];
			st_nxt.flush = i_wdata[`SBUF_LVL_FLUSH_BIT];
		end

		// Settling
		if (param_change || i_autocal_start ||
			(bcr_wr && i_wdata[`SBUF_BCR_SYNC_BIT])) begin
			st_nxt.settled = 1'b0;
			st_nxt.settle_cnt = `SBUF_SETTLE_INTERVALS;
		end else if (!st_r.settled && i_conv_tick) begin
			if (st_r.settle_cnt <= 8'h01) begin
				st_nxt.settled = 1'b1;
				st_nxt.settle_cnt = '0;
				st_nxt.settled_evt = 1'b1;
			end else begin
				st_nxt.settle_cnt = st_r.settle_cnt - 8'h01;
			end
		end

		// Fill level and its edges
		st_nxt.level = total;
		st_nxt.fill_flag = (total > 19'(st_r.thresh));
		if (i_fill_rising_sel) begin
			st_nxt.fill_evt = st_nxt.fill_flag && !st_r.fill_flag;
		end else begin
			st_nxt.fill_evt = !st_nxt.fill_flag && st_r.fill_flag;
		end

		// Read answers
		if (i_rd) begin
			st_nxt.rvalid = 1'b1;
			unique case (i_addr)
				`SBUF_OFS_BOARD_CTRL: st_nxt.rdata = bcr_view;
				`SBUF_OFS_LEVEL_CTRL: st_nxt.rdata = {12'h000, st_r.flush,
					st_r.intake_off, st_r.thresh};
				`SBUF_OFS_COUNT: st_nxt.rdata = {13'h0000, st_r.level};
				`SBUF_OFS_SAMPLE_READ: st_nxt.rdata = {12'h000, st_head};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= '0;
			st_r.input_config_select <= sbuf_pkg::input_config_e'(`SBUF_RST_CFG);
			st_r.span <= sbuf_pkg::input_span_e'(`SBUF_RST_SPAN);
			st_r.fmt_offset <= `SBUF_RST_FMT;
			st_r.thresh <= `SBUF_RST_THRESH;
			st_r.settled <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rdata = st_r.rdata;
	assign o_rvalid = st_r.rvalid;
	assign o_input_config_select = st_r.input_config_select;
	assign o_input_span = st_r.span;
	assign o_conv_sync = st_r.sync_pulse;
	assign o_settled_event = st_r.settled_evt;
	assign o_fill_event = st_r.fill_evt;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	a_span_follows: assert property (bcr_wr |=>
		o_input_span == $past(i_wdata[3:2]))
		else $error("span output does not follow write");

	a_config_follows: assert property (bcr_wr |=>
		o_input_config_select == $past(i_wdata[1:0]))
		else $error("config output does not follow write");

	a_settle_drop: assert property ((param_change || i_autocal_start) |=>
		!st_r.settled && st_r.settle_cnt == `SBUF_SETTLE_INTERVALS)
		else $error("settled flag did not drop on change");

	a_settle_len: assert property ($rose(st_r.settled) |->
		$past(st_r.settle_cnt) <= 8'h01 && $past(i_conv_tick))
		else $error("settled rose before count ran out");

	a_settled_evt: assert property ($rose(st_r.settled) |-> o_settled_event)
		else $error("no event on settled rising edge");

	a_fill_flag: assert property (##1 st_r.fill_flag ==
		($past(total) > 19'($past(st_r.thresh))))
		else $error("fill flag disagrees with level");

	// Edge select is looked at one cycle before the flag moves
	a_fill_edge: assert property ($past(i_fill_rising_sel) && $rose(st_r.fill_flag)
		|-> o_fill_event)
		else $error("rising fill edge gave no event");

	a_fill_fall: assert property (!$past(i_fill_rising_sel) && $fell(st_r.fill_flag)
		|-> o_fill_event)
		else $error("falling fill edge gave no event");

	a_flush_empty: assert property (st_r.flush |=> total == 19'h00000)
		else $error("flush did not empty buffer");

	a_intake_block: assert property (st_r.intake_off |=> total <= $past(total))
		else $error("blocked intake still stored samples");

	a_tag_format: assert property (xf_push |-> xf_wdata[19:16] == i_sample_chan &&
		xf_wdata[15] == (i_sample_data[15] ^ st_r.fmt_offset))
		else $error("entry tag or format wrong");

	a_read_oldest: assert property (data_rd && !st_empty && !st_r.flush |=>
		o_rvalid && o_rdata[19:0] == $past(st_head) &&
		st_count == $past(st_count) - (SAW+1)'(1) + (SAW+1)'($past(xf_pop)))
		else $error("sample read did not pop oldest entry");

	a_sync_pulse: assert property (bcr_wr && i_wdata[6] |=> o_conv_sync ##1 !o_conv_sync)
		else $error("sync pulse wrong");

endmodule // sample_buffer_and_input_config

// ### tb/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
	input wire logic i_clk,
	input wire logic [31:0] i_rdata,
	input wire logic i_rvalid,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [31:0] o_wdata
);
	initial begin
		o_addr = 8'hFF;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 32'hFFFFFFFF;
	end
	////////////////////////////////////////////////////////////////
	// Idle bus shows inverted values so stale words never match
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(posedge i_clk);
		#1;
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_rd = 1'b1;
		@(posedge i_clk);
		#1;
		o_rd = 1'b0;
		o_addr = ~a;
		d = (i_rvalid === 1'b1) ? i_rdata : 32'hXXXXXXXX;
	endtask
endmodule // host_bus_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error at %0t got %h expected %h", $time, (g), (e)); end end
module tb_top;
	logic i_clk, i_resetn, i_sample_valid, i_conv_tick, i_rate_change, i_autocal_start;
	logic i_fill_rising_sel, i_wr, i_rd, o_rvalid, o_conv_sync, o_settled_event, o_fill_event;
	logic [15:0] i_sample_data;
	logic [3:0] i_sample_chan;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, r;
	logic [1:0] o_input_config_select, o_input_span;
	int n_mismatch, checks, n_sev, n_fev, n_sync, e_sev;
	sample_buffer_and_input_config #(.XFER_DEPTH(256), .STORE_DEPTH(64)) i_dut (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
		.i_wdata(i_wdata), .i_sample_valid(i_sample_valid), .i_sample_data(i_sample_data),
		.i_sample_chan(i_sample_chan), .i_conv_tick(i_conv_tick),
		.i_rate_change(i_rate_change), .i_autocal_start(i_autocal_start),
		.i_fill_rising_sel(i_fill_rising_sel), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.o_input_config_select(o_input_config_select), .o_input_span(o_input_span),
		.o_conv_sync(o_conv_sync), .o_settled_event(o_settled_event),
		.o_fill_event(o_fill_event));
	host_bus_model i_host (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
		.o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_settled_event === 1'b1) n_sev++;
		if (o_fill_event === 1'b1) n_fev++;
		if (o_conv_sync === 1'b1) n_sync++;
	end
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic strobe(ref logic s);
		cyc(1);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic push(input logic [15:0] d, input logic [3:0] c);
		i_sample_data = d;
		i_sample_chan = c;
		strobe(i_sample_valid);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		i_host.rd(a, r);
		`CHK((r & m), e)
	endtask
	task automatic settle();
		repeat (129) strobe(i_conv_tick);
		rchk(8'h00, 32'h00002000, 32'h00000000);
		strobe(i_conv_tick);
		cyc(2);
		rchk(8'h00, 32'h00002000, 32'h00002000);
		e_sev++;
		`CHK(n_sev, e_sev)
	endtask
	////////////////////////////////////////////////////////////////
	// Budget far above the few thousand cycles the sequence needs
	initial begin
		#(40 * 40000);
		n_mismatch++;
		stop_test();
	end
	initial begin
		{i_sample_valid, i_conv_tick, i_rate_change, i_autocal_start} = 4'h0;
		i_sample_data = 16'h0000;
		i_sample_chan = 4'h0;
		i_fill_rising_sel = 1'b1;
		i_resetn = 1'b0;
		cyc(10);
		i_resetn = 1'b1;
		`CHK(o_input_span, 2'h3)
		`CHK(o_input_config_select, 2'h0)
		rchk(8'h00, 32'hFFFFFFFF, 32'h0000201C);
		rchk(8'h38, 32'hFFFFFFFF, 32'h0003FFFE);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000000);
		rchk(8'h10, 32'hFFFFFFFF, 32'h00000000);
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			i_host.wr(8'h00, 32'h10 | (c << 2) | c);
			cyc(1);
			`CHK(o_input_config_select, c[1:0])
			`CHK(o_input_span, c[1:0])
			rchk(8'h00, 32'h00002000, 32'h00000000);
			settle();
		end
		for (int k = 0; k < 3; k++) begin
			if (k == 0) strobe(i_rate_change);
			else if (k == 1) strobe(i_autocal_start);
			else i_host.wr(8'h00, 32'h0000005F);
			cyc(1);
			rchk(8'h00, 32'h00002040, 32'h00000000);
			settle();
		end
		`CHK(n_sync, 1)
		i_host.wr(8'h00, 32'h0000001D);
		cyc(1);
		`CHK(o_input_span, 2'h3)
		`CHK(o_input_config_select, 2'h1)
		settle();
		i_host.wr(8'h00, 32'h0000000D);
		cyc(1);
		rchk(8'h00, 32'h00002000, 32'h00002000);
		i_host.wr(8'h00, 32'h0000001D);
		$display("test settle done");
		push(16'h0000, 4'h3);
		push(16'h7FFF, 4'h5);
		push(16'h8000, 4'hF);
		i_host.wr(8'h00, 32'h0000000D);
		push(16'h0001, 4'h0);
		cyc(3);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000004);
		rchk(8'h48, 32'hFFFFFFFF, 32'h00038000);
		rchk(8'h48, 32'hFFFFFFFF, 32'h0005FFFF);
		rchk(8'h48, 32'hFFFFFFFF, 32'h000F0000);
		rchk(8'h48, 32'hFFFFFFFF, 32'h00000001);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000000);
		$display("test data done");
		i_host.wr(8'h38, 32'h00000002);
		repeat (3) push(16'h1234, 4'h1);
		cyc(3);
		rchk(8'h00, 32'h00004000, 32'h00004000);
		`CHK(n_fev, 1)
		i_host.rd(8'h48, r);
		cyc(3);
		rchk(8'h00, 32'h00004000, 32'h00000000);
		`CHK(n_fev, 1)
		i_fill_rising_sel = 1'b0;
		push(16'h1234, 4'h1);
		cyc(3);
		`CHK(n_fev, 1)
		i_host.rd(8'h48, r);
		cyc(3);
		`CHK(n_fev, 2)
		i_host.wr(8'h38, 32'h00000000);
		cyc(3);
		rchk(8'h00, 32'h00004000, 32'h00004000);
		repeat (2) i_host.rd(8'h48, r);
		cyc(3);
		rchk(8'h00, 32'h00004000, 32'h00000000);
		`CHK(n_fev, 3)
		$display("test fill done");
		repeat (2) push(16'h0042, 4'h2);
		i_host.wr(8'h38, 32'h0007FFFE);
		repeat (2) push(16'h0042, 4'h2);
		cyc(3);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000002);
		i_host.wr(8'h38, 32'h000BFFFE);
		cyc(2);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000000);
		push(16'h0042, 4'h2);
		cyc(3);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000000);
		rchk(8'h38, 32'hFFFFFFFF, 32'h000BFFFE);
		i_host.wr(8'h38, 32'h0003FFFE);
		push(16'h0042, 4'h2);
		cyc(3);
		rchk(8'h40, 32'hFFFFFFFF, 32'h00000001);
		$display("test flush done");
		stop_test();
	end
endmodule // tb_top
